// ==== hw/t2_defines.svh ====
// register offsets, field positions, reset values and tick counts
// assumes a 32-bit classic Wishbone slave with byte addresses
`ifndef T2_DEFINES_SVH
`define T2_DEFINES_SVH

`define T2_ADR_CTRL     8'h00
`define T2_ADR_MODE     8'h04
`define T2_ADR_CNT_LO   8'h08
`define T2_ADR_CNT_HI   8'h0C
`define T2_ADR_RLD_LO   8'h10
`define T2_ADR_RLD_HI   8'h14
`define T2_ADR_IRQ_STS  8'h18
`define T2_ADR_IRQ_MSK  8'h1C

`define T2_CTRL_RST     8'h00
`define T2_MODE_RST     8'h00
`define T2_CNT_RST      16'h0000
`define T2_RLD_RST      16'h0000
`define T2_IRQ_RST      2'h0

`define T2_CTRL_OVF_BIT 7
`define T2_CTRL_EXT_BIT 6
`define T2_STS_OVF_BIT  0
`define T2_STS_EXT_BIT  1
`define T2_MODE_MASK    8'h06

// last prescaler value: timer rate is osc/12 or osc/6, fast rate
// (baud and clock-out) is osc/2 or osc/1 so that clock-out gives
// osc / (n * (65536 - reload)) with n = 4 or 2
`define T2_DIV_SLOW12   4'hB
`define T2_DIV_SLOW6    4'h5
`define T2_DIV_FAST12   4'h1
`define T2_DIV_FAST6    4'h0
`define T2_CNT_MAX      16'hFFFF

`endif

// ==== hw/t2_pkg.sv ====
// types shared by the timer 2 block
// assumes t2_defines.svh holds the numbers
package t2_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic ovf_flag;
    logic ext_flag;
    logic rx_clk;
    logic tx_clk;
    logic ext_en;
    logic timer2_run;
    logic counter_timer_select;
    logic capture_sel;
  } t2_ctrl_t;

  // mode register layout
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic       six_clk;
    logic       clock_out_enable;
    logic       rsvd_lo;
  } t2_mode_t;

  typedef enum logic [1:0] {
    T2_F_RELOAD,
    T2_F_CAPTURE,
    T2_F_BAUD
  } t2_func_t;

  // events raised in one cycle
  typedef struct packed {
    logic ext;
    logic ovf;
  } t2_evt_t;

endpackage

// ==== hw/t2_edge_sync.sv ====
// two-flop synchroniser with falling-edge detect for a pin input
// assumes the pin is asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module t2_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // pin side
  input  wire logic pin_i,
  // synchronous side
  output logic      level_o,
  output logic      fall_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
    // third stage keeps the previous synchronised level
    last_d = sync_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else if (ce) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level_o = sync_q;
  // edge is judged on the second and third stage only, never the first
  assign fall_o  = last_q & ~sync_q;

endmodule
`default_nettype wire

// ==== hw/t2_timer.sv ====
// timer/counter 2: auto-reload, capture, baud ticks and clock-out
// assumes a classic Wishbone master and asynchronous pins
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "t2_defines.svh"
module t2_timer
  import t2_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o,
  // clock pin, count input or clock-out
  input  wire logic        clk_pin_i,
  output logic             clk_pin_o,
  output logic             clk_pin_oe,
  // external trigger pin
  input  wire logic        trig_pin_i,
  // baud ticks to the serial port
  output logic             rx_baud_tick_o,
  output logic             tx_baud_tick_o
);

  function automatic logic [3:0] div_last(input logic fast,
                                          input logic six);
    if (fast) begin
      div_last = six ? `T2_DIV_FAST6 : `T2_DIV_FAST12;
    end else begin
      div_last = six ? `T2_DIV_SLOW6 : `T2_DIV_SLOW12;
    end
  endfunction

  t2_ctrl_t    ctrl_q;
  t2_ctrl_t    ctrl_d;
  t2_mode_t    mode_q;
  t2_mode_t    mode_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] rld_q;
  logic [15:0] rld_d;
  logic [3:0]  pre_q;
  logic [3:0]  pre_d;
  logic [1:0]  sts_q;
  logic [1:0]  sts_d;
  logic [1:0]  msk_q;
  logic [1:0]  msk_d;
  logic        pin_q;
  logic        pin_d;
  logic        oe_q;
  logic        oe_d;
  logic        rx_q;
  logic        rx_d;
  logic        tx_q;
  logic        tx_d;
  logic        irq_q;
  logic        irq_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  logic        cnt_fall;
  logic        trg_fall;
  t2_evt_t     evt;
  t2_func_t    func;
  logic [1:0]  sts_clr;
  logic        baud;
  logic        clk_out;
  logic        fast;
  logic        step;
  logic        ovf;
  logic        trig;
  logic        access;
  logic        wr;

  t2_edge_sync u_cnt_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin_i   (clk_pin_i),
    .level_o (),
    .fall_o  (cnt_fall)
  );

  t2_edge_sync u_trg_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pin_i   (trig_pin_i),
    .level_o (),
    .fall_o  (trg_fall)
  );

  always_comb begin
    ctrl_d  = ctrl_q;
    mode_d  = mode_q;
    cnt_d   = cnt_q;
    rld_d   = rld_q;
    pre_d   = pre_q;
    msk_d   = msk_q;
    pin_d   = pin_q;
    rx_d    = 1'b0;
    tx_d    = 1'b0;
    ack_d   = 1'b0;
    dat_d   = 32'h0000_0000;
    evt     = '0;
    sts_clr = 2'h0;
    step    = 1'b0;

    baud    = ctrl_q.rx_clk | ctrl_q.tx_clk;
    clk_out = mode_q.clock_out_enable;
    fast    = baud | clk_out;
    // clock-out forces reload behaviour unless baud is set, capture has no meaning there
    if (baud) begin
      func = T2_F_BAUD;
    end else if (ctrl_q.capture_sel && !clk_out) begin
      func = T2_F_CAPTURE;
    end else begin
      func = T2_F_RELOAD;
    end

    // counting only while run is set, software starts it
    if (ctrl_q.timer2_run) begin
      if (ctrl_q.counter_timer_select) begin
        step = cnt_fall;
      // a rate change can leave the prescaler past its new end value
      end else if (pre_q >= div_last(fast, mode_q.six_clk)) begin
        pre_d = 4'h0;
        step  = 1'b1;
      end else begin
        pre_d = pre_q + 4'h1;
      end
    end

    ovf  = step && (cnt_q == `T2_CNT_MAX);
    trig = ctrl_q.ext_en && trg_fall;

    if (step) begin
      cnt_d = cnt_q + 16'h0001;
    end

    if (ovf) begin
      case (func)
        T2_F_CAPTURE: begin
          cnt_d   = 16'h0000;
          evt.ovf = 1'b1;
        end
        T2_F_BAUD: begin
          cnt_d = rld_q;
          rx_d  = ctrl_q.rx_clk;
          tx_d  = ctrl_q.tx_clk;
        end
        default: begin
          cnt_d   = rld_q;
          evt.ovf = !clk_out;
        end
      endcase
      if (clk_out) begin
        pin_d = ~pin_q;
      end
    end

    if (trig) begin
      evt.ext = 1'b1;
      case (func)
        T2_F_CAPTURE: begin
          rld_d = cnt_q;
        end
        T2_F_RELOAD: begin
          cnt_d = rld_q;
        end
        default: begin
          // baud mode: the edge only raises its flag
          cnt_d = cnt_d;
        end
      endcase
    end

    // pin drives only in clock-out with internal counting
    oe_d = clk_out && !ctrl_q.counter_timer_select;

    access = wb_cyc_i && wb_stb_i && !ack_q;
    wr     = access && wb_we_i && wb_sel_i[0];
    if (access) begin
      ack_d = 1'b1;
      if (wb_adr_i == `T2_ADR_CTRL) begin
        dat_d[7:0] = ctrl_q;
        dat_d[`T2_CTRL_OVF_BIT] = sts_q[`T2_STS_OVF_BIT];
        dat_d[`T2_CTRL_EXT_BIT] = sts_q[`T2_STS_EXT_BIT];
      end else if (wb_adr_i == `T2_ADR_MODE) begin
        dat_d[7:0] = mode_q;
      end else if (wb_adr_i == `T2_ADR_CNT_LO) begin
        dat_d[7:0] = cnt_q[7:0];
      end else if (wb_adr_i == `T2_ADR_CNT_HI) begin
        dat_d[7:0] = cnt_q[15:8];
      end else if (wb_adr_i == `T2_ADR_RLD_LO) begin
        dat_d[7:0] = rld_q[7:0];
      end else if (wb_adr_i == `T2_ADR_RLD_HI) begin
        dat_d[7:0] = rld_q[15:8];
      end else if (wb_adr_i == `T2_ADR_IRQ_STS) begin
        dat_d[1:0] = sts_q;
        if (!wb_we_i) begin
          sts_clr = sts_q;
        end
      end else if (wb_adr_i == `T2_ADR_IRQ_MSK) begin
        dat_d[1:0] = msk_q;
      end
    end

    // software writes win over the counter's own update
    if (wr) begin
      if (wb_adr_i == `T2_ADR_CTRL) begin
        ctrl_d = t2_ctrl_t'(wb_dat_i[7:0]);
        ctrl_d.ovf_flag = 1'b0;
        ctrl_d.ext_flag = 1'b0;
      end else if (wb_adr_i == `T2_ADR_MODE) begin
        mode_d = t2_mode_t'(wb_dat_i[7:0] & `T2_MODE_MASK);
      end else if (wb_adr_i == `T2_ADR_CNT_LO) begin
        cnt_d[7:0] = wb_dat_i[7:0];
      end else if (wb_adr_i == `T2_ADR_CNT_HI) begin
        cnt_d[15:8] = wb_dat_i[7:0];
      end else if (wb_adr_i == `T2_ADR_RLD_LO) begin
        rld_d[7:0] = wb_dat_i[7:0];
      end else if (wb_adr_i == `T2_ADR_RLD_HI) begin
        rld_d[15:8] = wb_dat_i[7:0];
      end else if (wb_adr_i == `T2_ADR_IRQ_MSK) begin
        msk_d = wb_dat_i[1:0];
      end
    end

    // a new event in the clearing cycle stays set
    sts_d = (sts_q & ~sts_clr) | {evt.ext, evt.ovf};
    irq_d = |(sts_d & msk_d);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= t2_ctrl_t'(`T2_CTRL_RST);
      mode_q <= t2_mode_t'(`T2_MODE_RST);
      cnt_q  <= `T2_CNT_RST;
      rld_q  <= `T2_RLD_RST;
      pre_q  <= 4'h0;
      sts_q  <= `T2_IRQ_RST;
      msk_q  <= `T2_IRQ_RST;
      pin_q  <= 1'b0;
      oe_q   <= 1'b0;
      rx_q   <= 1'b0;
      tx_q   <= 1'b0;
      irq_q  <= 1'b0;
      ack_q  <= 1'b0;
      dat_q  <= 32'h0000_0000;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      cnt_q  <= cnt_d;
      rld_q  <= rld_d;
      pre_q  <= pre_d;
      sts_q  <= sts_d;
      msk_q  <= msk_d;
      pin_q  <= pin_d;
      oe_q   <= oe_d;
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      irq_q  <= irq_d;
      ack_q  <= ack_d;
      dat_q  <= dat_d;
    end
  end

  assign wb_dat_o       = dat_q;
  assign wb_ack_o       = ack_q;
  assign irq_o          = irq_q;
  assign clk_pin_o      = pin_q;
  assign clk_pin_oe     = oe_q;
  assign rx_baud_tick_o = rx_q;
  assign tx_baud_tick_o = tx_q;

endmodule
`default_nettype wire

// ==== sim/t2_timer_monitor.sv ====
// concurrent checks on the timer 2 top ports
// assumes one clock domain and no bus request while ce is low
`timescale 1ns/100ps
`default_nettype none
module t2_timer_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // interrupt and clock pin
  input wire logic        irq_o,
  input wire logic        clk_pin_o,
  input wire logic        clk_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_byte: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data above low byte");
  a_oe_by_write: assert property ($changed(clk_pin_oe) |->
    $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("pin enable moved without a write");
  a_irq_drop: assert property ($fell(irq_o) |->
    $past(wb_stb_i) || $past(wb_stb_i, 2))
    else $error("interrupt fell without bus access");
  a_start_quiet: assert property ($rose(rst_n) |->
    !wb_ack_o && !irq_o && !clk_pin_oe)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// ==== sim/t2_pin_model.sv ====
// far side: trigger source and clock pin load
// assumes both pins idle high through pull-ups
`timescale 1ns/100ps
`default_nettype none
module t2_pin_model (
  // clock
  input  wire logic clk,
  // design pins
  input  wire logic clk_pin_o,
  input  wire logic clk_pin_oe,
  output logic      clk_pin_i,
  output logic      trig_pin_i
);
  logic ext_clk;
  // released pin follows the outside count source, idle at the pull-up
  assign clk_pin_i = clk_pin_oe ? clk_pin_o : ext_clk;
  initial trig_pin_i = 1'b1;
  initial ext_clk = 1'b1;
  // each level held four clocks, longer than the sync needs
  task automatic trig_fall();
    @(posedge clk) trig_pin_i <= 1'b0;
    repeat (4) @(posedge clk);
    trig_pin_i <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  // one falling count edge on the released clock pin
  task automatic count_fall();
    @(posedge clk) ext_clk <= 1'b0;
    repeat (4) @(posedge clk);
    ext_clk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the timer 2 block
// assumes design, monitor and pin model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic        clk_pin_o, clk_pin_oe, clk_pin_i, trig_pin_i, ce;
  logic        rx_baud_tick_o, tx_baud_tick_o;
  logic [7:0]  wb_adr_i, rd, d;
  logic [31:0] wb_dat_i, wb_dat_o;
  int          n_mismatch, cmp_count, cycles, n_rx, n_tx, hp;
  int          seed = 32'hB152BD09;
  // register address and its writable bits
  logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h1C, 8'h18, 8'h20};
  logic [7:0]  wm[7] = '{8'h3F, 8'h06, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00};
  logic [7:0]  cd[13] = '{8'h34, 8'h36, 8'h26, 8'h14, 8'h16, 8'h00, 8'h08,
                         8'h01, 8'h09, 8'h02, 8'h03, 8'h0A, 8'h0B};
  t2_timer i_t2_timer (
    .clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .clk_pin_i,
    .clk_pin_o, .clk_pin_oe, .trig_pin_i, .rx_baud_tick_o, .tx_baud_tick_o
  );
  t2_pin_model i_t2_pin_model (
    .clk, .clk_pin_o, .clk_pin_oe, .clk_pin_i, .trig_pin_i
  );
  always #5 clk = ~clk;
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (rx_baud_tick_o === 1'b1) n_rx++;
    if (tx_baud_tick_o === 1'b1) n_tx++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, dw);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, dw};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, dw);
    bus(1'b1, a, dw);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, e);
  endtask
  // cycles between two clock-out edges
  task automatic half(output int n);
    logic v;
    n = 0;
    v = clk_pin_o;
    while (clk_pin_o === v) @(posedge clk);
    v = clk_pin_o;
    while (clk_pin_o === v) begin
      @(posedge clk);
      n++;
    end
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {n_mismatch, cmp_count, cycles, n_rx, n_tx} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc("reset", 8'(i * 4), 8'h00);
    repeat (3) for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed));
      wr(ra[i], d);
      bus(1'b0, ra[i], 8'h00);
      chk("readback", rd & (i == 0 ? 8'h3F : 8'hFF), d & wm[i]);
    end
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr16(8'h10, 16'hFFF0);
    wr16(8'h08, 16'hFFF0);
    foreach (cd[i]) begin
      wr(8'h00, cd[i]);
      repeat (4) @(posedge clk);
      {n_rx, n_tx} = '0;
      repeat (200) @(posedge clk);
      chk("rx_tick", n_rx > 0, cd[i][5] & ~cd[i][1]);
      chk("tx_tick", n_tx > 0, cd[i][4] & ~cd[i][1]);
    end
    bus(1'b0, 8'h18, 8'h00);
    wr(8'h1C, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(8'h04, s ? 8'h06 : 8'h02);
      wr(8'h00, s ? 8'h34 : 8'h04);
      half(hp);
      half(hp);
      chk("half_period", hp, (s ? 1 : 2) * (65536 - 'hFFF0));
      chk("pin_oe", clk_pin_oe, 1'b1);
      rc("sts_quiet", 8'h18, 8'h00);
      chk("irq_quiet", irq_o, 1'b0);
    end
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h1C, 8'h00);
    wr(8'h00, 8'h04);
    repeat (400) @(posedge clk);
    wr(8'h00, 8'h00);
    chk("irq_masked", irq_o, 1'b0);
    rc("cnt_hi", 8'h0C, 8'hFF);
    wr(8'h1C, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_set", irq_o, 1'b1);
    rc("sts_ovf", 8'h18, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq_clear", irq_o, 1'b0);
    wr16(8'h10, 16'h1234);
    wr16(8'h08, 16'h0000);
    i_t2_pin_model.trig_fall();
    rc("sts_trig_off", 8'h18, 8'h00);
    rc("cnt_kept", 8'h0C, 8'h00);
    wr(8'h00, 8'h08);
    i_t2_pin_model.trig_fall();
    rc("sts_trig", 8'h18, 8'h02);
    rc("cnt_reload", 8'h0C, 8'h12);
    wr16(8'h08, 16'h0000);
    wr(8'h00, 8'h38);
    i_t2_pin_model.trig_fall();
    rc("baud_no_load", 8'h0C, 8'h00);
    wr(8'h00, 8'h09);
    d = 8'($random(seed));
    wr16(8'h08, {d, ~d});
    i_t2_pin_model.trig_fall();
    rc("capture", 8'h14, d);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h02);
    wr16(8'h08, 16'h0000);
    wr(8'h00, 8'h06);
    repeat (5) i_t2_pin_model.count_fall();
    chk("pin_oe_off", clk_pin_oe, 1'b0);
    rc("ext_count", 8'h08, 8'h05);
    ce <= 1'b0;
    repeat (2) i_t2_pin_model.count_fall();
    ce <= 1'b1;
    rc("ce_hold", 8'h08, 8'h05);
    give_verdict();
  end
endmodule
bind t2_timer t2_timer_monitor i_t2_timer_monitor (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .irq_o,
  .clk_pin_o, .clk_pin_oe
);
`default_nettype wire
